// File: design/bgfs_pkg.sv
// Constants, register map and field layout of the bridge gating fault supervisor.
package bgfs_pkg;

  // ****************************************************************
  // Sizes.
  // ****************************************************************
  localparam int GATE_W  = 4;
  localparam int CAUSE_W = 8;
  localparam int LIM_W   = 16;
  localparam int ADDR_W  = 6;

  // ****************************************************************
  // Fault cause bit positions.
  // ****************************************************************
  localparam int C_OVERCURRENT = 0;
  localparam int C_OVERVOLTAGE = 1;
  localparam int C_TEMP0       = 2;
  localparam int C_SUPPLY_LOW  = 6;
  localparam int C_SUPPLY_HIGH = 7;
  localparam int TEMP_N        = 4;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [ADDR_W-1:0] A_CTRL      = 6'h00;
  localparam logic [ADDR_W-1:0] A_STATUS    = 6'h04;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT  = 6'h08;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK  = 6'h0c;
  localparam logic [ADDR_W-1:0] A_SAFE_SEL  = 6'h10;
  localparam logic [ADDR_W-1:0] A_LIM_CUR   = 6'h14;
  localparam logic [ADDR_W-1:0] A_LIM_VDC   = 6'h18;
  localparam logic [ADDR_W-1:0] A_LIM_TEMP  = 6'h1c;
  localparam logic [ADDR_W-1:0] A_LIM_SUPLO = 6'h20;
  localparam logic [ADDR_W-1:0] A_LIM_SUPHI = 6'h24;
  localparam int CTRL_ACK_BIT = 0;

  // ****************************************************************
  // Reset values: limits in 10 mA, 100 mV, 0.1 degC and 1 mV units.
  // ****************************************************************
  localparam logic [LIM_W-1:0]   LIM_CUR_RST   = 16'h09c4;
  localparam logic [LIM_W-1:0]   LIM_VDC_RST   = 16'h09c4;
  localparam logic [LIM_W-1:0]   LIM_TEMP_RST  = 16'h0384;
  localparam logic [LIM_W-1:0]   LIM_SUPLO_RST = 16'h1194;
  localparam logic [LIM_W-1:0]   LIM_SUPHI_RST = 16'h157c;
  localparam logic [CAUSE_W-1:0] SAFE_SEL_RST  = 8'h00;
  localparam logic [CAUSE_W-1:0] IRQ_MASK_RST  = 8'h00;

  // ****************************************************************
  // Safe switching states.
  // ****************************************************************
  localparam logic [GATE_W-1:0] GATE_BLOCKED = 4'h0;
  localparam logic [GATE_W-1:0] GATE_SHORT   = 4'ha;

  // ****************************************************************
  // Timing: fast sample rate derived from the clock.
  // ****************************************************************
  localparam int CLK_KHZ         = 200000;
  localparam int SAMPLE_KSPS     = 150;
  localparam int SAMPLE_CYC      = CLK_KHZ / SAMPLE_KSPS;
  localparam int SAMPLE_CNT_W    = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: design/bgfs_sync.sv
// Two flip-flop synchroniser bank for inputs from outside the clock domain.
`timescale 1ns/100ps
module bgfs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// File: design/bgfs_top.sv
// Gating pass-through, fault latching, safe-state override and AXI4-Lite registers.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps

module bgfs_top (
  input  wire logic                           CLK_I,
  input  wire logic                           RESET_N_I,
  input  wire logic [bgfs_pkg::GATE_W-1:0]    GATE_IN_I,
  input  wire logic                           FAST_OVERCURRENT_I,
  input  wire logic                           FAST_OVERVOLTAGE_I,
  input  wire logic [bgfs_pkg::TEMP_N-1:0]    SLOW_OVERTEMP_I,
  input  wire logic                           SLOW_SUPPLY_LOW_I,
  input  wire logic                           SLOW_SUPPLY_HIGH_I,
  input  wire logic                           ACK_BUTTON_I,
  output logic      [bgfs_pkg::GATE_W-1:0]    GATE_O,
  output logic      [bgfs_pkg::CAUSE_W-1:0]   FAULT_FLAGS_O,
  output logic                                ERROR_N_O,
  output logic                                IRQ_O,
  output logic                                SAMPLE_TICK_O,
  output logic      [bgfs_pkg::LIM_W-1:0]     LIM_CUR_O,
  output logic      [bgfs_pkg::LIM_W-1:0]     LIM_VDC_O,
  output logic      [bgfs_pkg::LIM_W-1:0]     LIM_TEMP_O,
  output logic      [bgfs_pkg::LIM_W-1:0]     LIM_SUPLO_O,
  output logic      [bgfs_pkg::LIM_W-1:0]     LIM_SUPHI_O,
  input  wire logic [bgfs_pkg::ADDR_W-1:0]    AWADDR,
  input  wire logic                           AWVALID,
  output logic                                AWREADY,
  input  wire logic [31:0]                    WDATA,
  input  wire logic [3:0]                     WSTRB,
  input  wire logic                           WVALID,
  output logic                                WREADY,
  output logic      [1:0]                     BRESP,
  output logic                                BVALID,
  input  wire logic                           BREADY,
  input  wire logic [bgfs_pkg::ADDR_W-1:0]    ARADDR,
  input  wire logic                           ARVALID,
  output logic                                ARREADY,
  output logic      [31:0]                    RDATA,
  output logic      [1:0]                     RRESP,
  output logic                                RVALID,
  input  wire logic                           RREADY
);
  import bgfs_pkg::*;

  localparam int SYNC_W = GATE_W + CAUSE_W + 1;

  // ****************************************************************
  // Input synchronisation.
  // ****************************************************************
  logic [SYNC_W-1:0]  sync_in;
  logic [SYNC_W-1:0]  sync_out;
  logic [GATE_W-1:0]  gate_s;
  logic [CAUSE_W-1:0] flag_s;
  logic               ack_s;

  assign sync_in = {ACK_BUTTON_I, SLOW_SUPPLY_HIGH_I, SLOW_SUPPLY_LOW_I, SLOW_OVERTEMP_I,
                    FAST_OVERVOLTAGE_I, FAST_OVERCURRENT_I, GATE_IN_I};

  bgfs_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   (sync_in),
    .sync_o    (sync_out)
  );

  assign gate_s = sync_out[GATE_W-1:0];
  assign flag_s = sync_out[GATE_W +: CAUSE_W];
  assign ack_s  = sync_out[SYNC_W-1];

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [CAUSE_W-1:0] fault_lat_r;
  logic [CAUSE_W-1:0] irq_stat_r;
  logic [CAUSE_W-1:0] irq_mask_r;
  logic [CAUSE_W-1:0] safe_sel_r;
  logic [LIM_W-1:0]   lim_cur_r;
  logic [LIM_W-1:0]   lim_vdc_r;
  logic [LIM_W-1:0]   lim_temp_r;
  logic [LIM_W-1:0]   lim_suplo_r;
  logic [LIM_W-1:0]   lim_suphi_r;
  logic               soft_ack_r;

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  logic [ADDR_W-1:0] wr_addr_r;
  logic [31:0]       wr_data_r;
  logic [3:0]        wr_strb_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic              wr_do;
  logic              wr_hit;
  logic [31:0]       wr_bits;
  logic [31:0]       wr_mask;

  assign wr_do   = aw_held_r && w_held_r && !BVALID;
  assign wr_mask = {{8{wr_strb_r[3]}}, {8{wr_strb_r[2]}}, {8{wr_strb_r[1]}}, {8{wr_strb_r[0]}}};
  assign wr_bits = wr_mask & wr_data_r;

  always_comb begin
    case (wr_addr_r)
      A_CTRL, A_STATUS, A_IRQ_STAT, A_IRQ_MASK, A_SAFE_SEL, A_LIM_CUR,
      A_LIM_VDC, A_LIM_TEMP, A_LIM_SUPLO, A_LIM_SUPHI: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      wr_strb_r <= '0;
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
    end else begin
      AWREADY <= !aw_held_r && !(AWVALID && AWREADY);
      WREADY  <= !w_held_r && !(WVALID && WREADY);
      if (AWVALID && AWREADY) begin
        aw_held_r <= 1'b1;
        wr_addr_r <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held_r  <= 1'b1;
        wr_data_r <= WDATA;
        wr_strb_r <= WSTRB;
      end
      if (wr_do) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Writable configuration registers.
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_mask_r  <= IRQ_MASK_RST;
      safe_sel_r  <= SAFE_SEL_RST;
      lim_cur_r   <= LIM_CUR_RST;
      lim_vdc_r   <= LIM_VDC_RST;
      lim_temp_r  <= LIM_TEMP_RST;
      lim_suplo_r <= LIM_SUPLO_RST;
      lim_suphi_r <= LIM_SUPHI_RST;
      soft_ack_r  <= 1'b0;
    end else begin
      soft_ack_r <= wr_do && (wr_addr_r == A_CTRL) && wr_bits[CTRL_ACK_BIT];
      if (wr_do) begin
        case (wr_addr_r)
          A_IRQ_MASK:  irq_mask_r  <= (irq_mask_r & ~wr_mask[CAUSE_W-1:0]) | wr_bits[CAUSE_W-1:0];
          A_SAFE_SEL:  safe_sel_r  <= (safe_sel_r & ~wr_mask[CAUSE_W-1:0]) | wr_bits[CAUSE_W-1:0];
          A_LIM_CUR:   lim_cur_r   <= (lim_cur_r & ~wr_mask[LIM_W-1:0]) | wr_bits[LIM_W-1:0];
          A_LIM_VDC:   lim_vdc_r   <= (lim_vdc_r & ~wr_mask[LIM_W-1:0]) | wr_bits[LIM_W-1:0];
          A_LIM_TEMP:  lim_temp_r  <= (lim_temp_r & ~wr_mask[LIM_W-1:0]) | wr_bits[LIM_W-1:0];
          A_LIM_SUPLO: lim_suplo_r <= (lim_suplo_r & ~wr_mask[LIM_W-1:0]) | wr_bits[LIM_W-1:0];
          A_LIM_SUPHI: lim_suphi_r <= (lim_suphi_r & ~wr_mask[LIM_W-1:0]) | wr_bits[LIM_W-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Fault latch and interrupt status.
  // ****************************************************************
  logic               ack_any;
  logic [CAUSE_W-1:0] fault_nxt;
  logic [CAUSE_W-1:0] irq_clr;

  assign ack_any   = ack_s || soft_ack_r;
  // A still-active cause re-latches even while acknowledged.
  assign fault_nxt = (ack_any ? '0 : fault_lat_r) | flag_s;
  assign irq_clr   = (wr_do && wr_addr_r == A_IRQ_STAT) ? wr_bits[CAUSE_W-1:0] : '0;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fault_lat_r <= '0;
    end else begin
      fault_lat_r <= fault_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | (flag_s & ~fault_lat_r);
    end
  end

  // ****************************************************************
  // Gate drive and fault outputs.
  // ****************************************************************
  logic [GATE_W-1:0] gate_nxt;

  always_comb begin
    if (fault_lat_r == '0) begin
      gate_nxt = gate_s;
    end else if ((fault_lat_r & ~safe_sel_r) != '0) begin
      gate_nxt = GATE_BLOCKED;
    end else begin
      gate_nxt = GATE_SHORT;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      GATE_O        <= GATE_BLOCKED;
      FAULT_FLAGS_O <= '0;
      ERROR_N_O     <= 1'b1;
      IRQ_O         <= 1'b0;
    end else begin
      GATE_O        <= gate_nxt;
      FAULT_FLAGS_O <= fault_lat_r;
      ERROR_N_O     <= (fault_lat_r == '0);
      IRQ_O         <= |(irq_stat_r & irq_mask_r);
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LIM_CUR_O   <= LIM_CUR_RST;
      LIM_VDC_O   <= LIM_VDC_RST;
      LIM_TEMP_O  <= LIM_TEMP_RST;
      LIM_SUPLO_O <= LIM_SUPLO_RST;
      LIM_SUPHI_O <= LIM_SUPHI_RST;
    end else begin
      LIM_CUR_O   <= lim_cur_r;
      LIM_VDC_O   <= lim_vdc_r;
      LIM_TEMP_O  <= lim_temp_r;
      LIM_SUPLO_O <= lim_suplo_r;
      LIM_SUPHI_O <= lim_suphi_r;
    end
  end

  // ****************************************************************
  // Fast sample tick for the fast-sampling controller.
  // ****************************************************************
  localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_CNT_W'(SAMPLE_CYC - 1);
  logic [SAMPLE_CNT_W-1:0] sample_cnt_r;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sample_cnt_r  <= '0;
      SAMPLE_TICK_O <= 1'b0;
    end else begin
      SAMPLE_TICK_O <= (sample_cnt_r == SAMPLE_LAST);
      sample_cnt_r  <= (sample_cnt_r == SAMPLE_LAST) ? '0 : sample_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (ARADDR)
      A_CTRL:      rd_mux = '0;
      A_STATUS:    rd_mux = {16'h0000, flag_s, fault_lat_r};
      A_IRQ_STAT:  rd_mux = {24'h000000, irq_stat_r};
      A_IRQ_MASK:  rd_mux = {24'h000000, irq_mask_r};
      A_SAFE_SEL:  rd_mux = {24'h000000, safe_sel_r};
      A_LIM_CUR:   rd_mux = {16'h0000, lim_cur_r};
      A_LIM_VDC:   rd_mux = {16'h0000, lim_vdc_r};
      A_LIM_TEMP:  rd_mux = {16'h0000, lim_temp_r};
      A_LIM_SUPLO: rd_mux = {16'h0000, lim_suplo_r};
      A_LIM_SUPHI: rd_mux = {16'h0000, lim_suphi_r};
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= RESP_OKAY;
    end else begin
      ARREADY <= !RVALID && !(ARVALID && ARREADY);
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA  <= rd_mux;
        RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_gate_passthru: assert property (
    (fault_lat_r == '0) |=> (GATE_O == $past(gate_s)))
    else $error("Gate output does not follow gating input without fault.");
  a_gate_forced: assert property (
    (fault_lat_r != '0) |=> (GATE_O == GATE_BLOCKED || GATE_O == GATE_SHORT))
    else $error("Gate output not in a safe state during fault.");
  a_block_wins: assert property (
    ((fault_lat_r & ~safe_sel_r) != '0) |=> (GATE_O == GATE_BLOCKED))
    else $error("Blocked state not applied for a blocking cause.");
  a_current_trip: assert property (
    flag_s[C_OVERCURRENT] |=> fault_lat_r[C_OVERCURRENT] ##1 (GATE_O != $past(gate_s) ||
      GATE_O == GATE_BLOCKED || GATE_O == GATE_SHORT))
    else $error("Overcurrent flag did not latch a fault.");

  a_supply_trip: assert property (
    (flag_s[C_SUPPLY_LOW] || flag_s[C_SUPPLY_HIGH]) |=> ##1 !ERROR_N_O)
    else $error("Supply fault did not pull the error line low.");
  a_sample_tick: assert property (
    SAMPLE_TICK_O |=> !SAMPLE_TICK_O [*8])
    else $error("Sample tick repeats too soon.");
  a_temp_trip: assert property (
    (flag_s[C_TEMP0 +: TEMP_N] != '0) |=> ##1 (FAULT_FLAGS_O[C_TEMP0 +: TEMP_N] != '0))
    else $error("Temperature flag not shown in output flags.");

  a_flags_follow: assert property (
    ##1 (FAULT_FLAGS_O == $past(fault_lat_r)))
    else $error("Output flags do not follow latched faults.");

  a_error_low: assert property (
    (fault_lat_r != '0) |=> !ERROR_N_O)
    else $error("Error line not low during fault.");

  a_fault_held: assert property (
    (!ack_any && fault_lat_r != '0) |=> ((fault_lat_r & $past(fault_lat_r)) ==
      $past(fault_lat_r)))
    else $error("Latched fault cleared without acknowledge.");

  a_sync_depth: assert property (
    ##2 (gate_s == $past(GATE_IN_I, 2)))
    else $error("Gating input not delayed by two stages.");

  a_bresp_hold: assert property (
    (BVALID && !BREADY) |=> (BVALID && $stable(BRESP)))
    else $error("Write response dropped before taken.");

endmodule

// File: sim/bgfs_far_model.sv
// Far-side model: master controller gating, sampling controllers' flags and the ack button.
`timescale 1ns/100ps
module bgfs_far_model (
  input  wire logic                          clk_i,
  input  wire logic [bgfs_pkg::GATE_W-1:0]   gate_cmd_i,
  input  wire logic [bgfs_pkg::CAUSE_W-1:0]  fault_cmd_i,
  input  wire logic                          ack_cmd_i,
  output logic      [bgfs_pkg::GATE_W-1:0]   gate_o,
  output logic      [bgfs_pkg::CAUSE_W-1:0]  flags_o,
  output logic                               ack_o
);
  import bgfs_pkg::*;

  // *********************************************
  // Pins change just after the edge, like a remote board.
  // *********************************************
  always_ff @(posedge clk_i) begin
    gate_o <= gate_cmd_i;
  end

  // Each flag follows its fault command, registered on the clock edge.
  always_ff @(posedge clk_i) begin
    flags_o <= fault_cmd_i;
  end

  always_ff @(posedge clk_i) begin
    ack_o <= ack_cmd_i;
  end
endmodule

// File: sim/test_bgfs_top.sv
// Self-checking bench for the bridge gating fault supervisor.
`timescale 1ns/100ps
module test_bgfs_top;
  import bgfs_pkg::*;

  // *********************************************
  // Signals.
  // *********************************************
  localparam logic [CAUSE_W-1:0] SEL = 8'h55;
  localparam logic [ADDR_W-1:0]  LIM_A [5] = '{A_LIM_CUR, A_LIM_VDC, A_LIM_TEMP,
                                              A_LIM_SUPLO, A_LIM_SUPHI};
  localparam logic [LIM_W-1:0]   LIM_R [5] = '{LIM_CUR_RST, LIM_VDC_RST, LIM_TEMP_RST,
                                              LIM_SUPLO_RST, LIM_SUPHI_RST};
  logic               clk;
  logic               rst_n;
  logic [GATE_W-1:0]  gate_cmd;
  logic [GATE_W-1:0]  gate_pin;
  logic [GATE_W-1:0]  gate_o;
  logic [GATE_W-1:0]  eg;
  logic [CAUSE_W-1:0] fault_cmd;
  logic [CAUSE_W-1:0] flag_pin;
  logic [CAUSE_W-1:0] flags_o;
  logic               ack_cmd, ack_pin, err_n, irq, tick;
  logic [LIM_W-1:0]   lim [5];
  logic [ADDR_W-1:0]  awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  int                 fails, n_compared, n, cnt;
  logic [3:0]         strb;
  int                 bwait;

  bgfs_far_model far (.clk_i(clk), .gate_cmd_i(gate_cmd), .fault_cmd_i(fault_cmd),
    .ack_cmd_i(ack_cmd), .gate_o(gate_pin), .flags_o(flag_pin), .ack_o(ack_pin));

  bgfs_top dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .GATE_IN_I(gate_pin), .ACK_BUTTON_I(ack_pin),
    .FAST_OVERCURRENT_I(flag_pin[0]), .FAST_OVERVOLTAGE_I(flag_pin[1]),
    .SLOW_OVERTEMP_I(flag_pin[5:2]), .SLOW_SUPPLY_LOW_I(flag_pin[6]),
    .SLOW_SUPPLY_HIGH_I(flag_pin[7]), .GATE_O(gate_o), .FAULT_FLAGS_O(flags_o),
    .ERROR_N_O(err_n), .IRQ_O(irq), .SAMPLE_TICK_O(tick), .LIM_CUR_O(lim[0]),
    .LIM_VDC_O(lim[1]), .LIM_TEMP_O(lim[2]), .LIM_SUPLO_O(lim[3]), .LIM_SUPHI_O(lim[4]),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // *********************************************
  // Tasks.
  // *********************************************
  task conclude;
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Every handshake and tick wait counts edges; running out ends the run as a failure.
  task automatic guard(inout int k);
    k++;
    if (k > 2000) begin
      fails++;
      conclude();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int  k;
    bit  ap;
    bit  wp;
    k = 0;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (bwait == 0);
    do begin
      @(posedge clk);
      guard(k);
      if (ap && awready === 1'b1) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end while (ap || wp);
    do begin
      @(posedge clk);
      guard(k);
      if (k >= bwait && bready !== 1'b1) begin
        bready <= 1'b1;
      end
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    chk("BRESP", 32'(er), 32'(bresp));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      guard(k);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      guard(k);
    end while (rvalid !== 1'b1);
    chk("RDATA", ed, rdata);
    chk("RRESP", 32'(er), 32'(rresp));
    rready <= 1'b0;
  endtask

  task automatic outs(input logic [3:0] g, input logic [7:0] f, input logic e, input logic i);
    chk("GATE_O", 32'(g), 32'(gate_o));
    chk("FAULT_FLAGS_O", 32'(f), 32'(flags_o));
    chk("ERROR_N_O", 32'(e), 32'(err_n));
    chk("IRQ_O", 32'(i), 32'(irq));
  endtask

  task automatic press;
    ack_cmd <= 1'b1;
    cyc(6);
    ack_cmd <= 1'b0;
    cyc(6);
  endtask

  // *********************************************
  // Main sequence.
  // *********************************************
  initial begin
    fails = 0;
    n_compared = 0;
    strb = 4'hf;
    bwait = 0;
    {rst_n, ack_cmd, awvalid, wvalid, bready, arvalid, rready} = '0;
    {gate_cmd, fault_cmd, awaddr, araddr, wdata, wstrb} = '0;
    cyc(3);
    outs(GATE_BLOCKED, 8'h00, 1'b1, 1'b0);
    rst_n <= 1'b1;
    cyc(3);
    for (int k = 0; k < 5; k++) begin
      rd(LIM_A[k], 32'(LIM_R[k]), RESP_OKAY);
      chk("LIM_O", 32'(LIM_R[k]), 32'(lim[k]));
    end
    rd(A_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    rd(6'h28, 32'h0000_0000, RESP_SLVERR);
    bwait = 10;
    wr(6'h2c, 32'h0000_00ff, RESP_SLVERR);
    bwait = 0;
    wr(A_LIM_CUR, 32'h0000_1234, RESP_OKAY);
    rd(A_LIM_CUR, 32'h0000_1234, RESP_OKAY);
    chk("LIM_CUR_O", 32'h0000_1234, 32'(lim[0]));
    strb = 4'h1;
    wr(A_LIM_VDC, 32'h0000_ab12, RESP_OKAY);
    strb = 4'hf;
    rd(A_LIM_VDC, {16'h0000, LIM_VDC_RST[15:8], 8'h12}, RESP_OKAY);
    for (int p = 0; p < 16; p++) begin
      eg = gate_o;
      gate_cmd <= 4'(p);
      cyc(4);
      chk("GATE_O held", 32'(eg), 32'(gate_o));
      cyc(1);
      chk("GATE_O", p, 32'(gate_o));
    end
    wr(A_SAFE_SEL, 32'(SEL), RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      eg = SEL[i] ? GATE_SHORT : GATE_BLOCKED;
      wr(A_IRQ_MASK, i[0] ? 32'h0000_00ff : 32'h0000_0000, RESP_OKAY);
      fault_cmd <= 8'h01 << i;
      cyc(8);
      outs(eg, 8'h01 << i, 1'b0, i[0]);
      rd(A_STATUS, 32'h0000_0101 << i, RESP_OKAY);
      fault_cmd <= 8'h00;
      cyc(6);
      outs(eg, 8'h01 << i, 1'b0, i[0]);
      if (i < 4) begin
        press();
      end else begin
        wr(A_CTRL, 32'h0000_0001, RESP_OKAY);
        cyc(4);
      end
      outs(4'hf, 8'h00, 1'b1, i[0]);
      rd(A_IRQ_STAT, 32'h0000_0001 << i, RESP_OKAY);
      wr(A_IRQ_STAT, 32'h0000_0001 << i, RESP_OKAY);
      cyc(3);
      chk("IRQ_O", 32'h0000_0000, 32'(irq));
    end
    fault_cmd <= 8'h05;
    cyc(8);
    outs(GATE_SHORT, 8'h05, 1'b0, 1'b1);
    fault_cmd <= 8'h07;
    cyc(8);
    outs(GATE_BLOCKED, 8'h07, 1'b0, 1'b1);
    press();
    outs(GATE_BLOCKED, 8'h07, 1'b0, 1'b1);
    fault_cmd <= 8'h00;
    press();
    outs(4'hf, 8'h00, 1'b1, 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      guard(n);
    end while (tick !== 1'b1);
    cnt = 0;
    n = 0;
    do begin
      @(posedge clk);
      cnt++;
      guard(n);
    end while (tick !== 1'b1);
    chk("SAMPLE_TICK_O period", SAMPLE_CYC, cnt);
    conclude();
  end
endmodule
